// ### design/mii_tx_pkg.sv
/*
  shared constants for the mii transmit port: strap codes, settle counts, clock figures.
  assumes nothing beyond a single 50 MHz system clock.
*/
`default_nettype none
package mii_tx_pkg;
  // strap codes that select the external phy
  localparam logic [3:0] STRAP_EXT_PHY_A = 4'h1;
  localparam logic [3:0] STRAP_EXT_PHY_B = 4'h2;
  localparam int STRAP_BITS = 4;
  // cycles after reset release before the strap is caught; covers the two sync stages
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [1:0] SETTLE_RESET = 2'h0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TXC_MIN_PERIOD_NS = 40;
  // fastest link clock in system clocks, rounded down; edge finding needs at least two
  localparam int TXC_MIN_CYCLES = TXC_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_WIDTH = 8;
  localparam logic [3:0] NIBBLE_IDLE = 4'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
endpackage
`default_nettype wire

// ### design/mii_sync_if.sv
/*
  carrier for the synchronised phy inputs between the synchroniser and the port logic.
  assumes both ends run on the system clock.
*/
`default_nettype none
interface mii_sync_if;
  logic tx_clock;
  logic carrier;
  logic collision;
  logic duplex_n;
  logic [mii_tx_pkg::STRAP_BITS-1:0] strap;
  modport source(output tx_clock, output carrier, output collision, output duplex_n, output strap);
  modport sink(input tx_clock, input carrier, input collision, input duplex_n, input strap);
endinterface
`default_nettype wire

// ### design/input_synchroniser.sv
/*
  two flip-flop synchroniser for every phy pin and strap that enters the clk domain.
  assumes the inputs are asynchronous levels; only the second stage leaves this module.
*/
`default_nettype none
module input_synchroniser (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_clock_raw,
  input wire logic carrier_raw,
  input wire logic collision_raw,
  input wire logic duplex_n_raw,
  input wire logic [mii_tx_pkg::STRAP_BITS-1:0] strap_raw,
  mii_sync_if.source s
);
  logic [mii_tx_pkg::SYNC_WIDTH-1:0] stage1;
  logic [mii_tx_pkg::SYNC_WIDTH-1:0] stage2;
  logic [mii_tx_pkg::SYNC_WIDTH-1:0] raw;

  assign raw = {strap_raw, duplex_n_raw, collision_raw, carrier_raw, tx_clock_raw};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
    end
  end

  assign s.tx_clock = stage2[0];
  assign s.carrier = stage2[1];
  assign s.collision = stage2[2];
  assign s.duplex_n = stage2[3];
  assign s.strap = stage2[7:4];
endmodule // input_synchroniser
`default_nettype wire

// ### design/mii_transmit_side_port.sv
/*
  mii transmit port toward an external phy: byte stream in, nibbles out on the phy transmit clock.
  assumes the phy transmit clock is sampled by clk and is at most half the clk rate.
*/
// What this block does
// - the mii port is enabled only when the strap holds one of the two external phy codes.
// - the transmit enable rises in the same link cycle as the first nibble of a frame.
// - the transmit enable falls once the last nibble has been clocked out.
// - data leaves four bits at a time, updated only on rising edges of the phy transmit clock.
// - bit 3 of each nibble is the most significant, bit 0 the least.
// - the phy transmit clock times the data and also paces the network core logic.
// - collision is synchronised first and acted on only in half duplex.
// - the active low duplex input selects full duplex when low and half duplex when high.
`default_nettype none
module mii_transmit_side_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mii_tx_clock_in,
  input wire logic mii_carrier_in,
  input wire logic mii_collision_in,
  input wire logic duplex_select_n,
  input wire logic [3:0] phy_select_strap,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_abort,
  output logic network_core_clock_en,
  output logic mii_port_enabled,
  output logic full_duplex,
  output logic mii_transmit_valid,
  output logic mii_tx_nibble_msb,
  output logic [2:0] mii_tx_nibble_low
);
  typedef enum logic [1:0] {st_idle, st_high, st_low, st_stop} tx_state_e;

  mii_sync_if sync_bus ();

  input_synchroniser u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .tx_clock_raw(mii_tx_clock_in),
    .carrier_raw(mii_carrier_in),
    .collision_raw(mii_collision_in),
    .duplex_n_raw(duplex_select_n),
    .strap_raw(phy_select_strap),
    .s(sync_bus)
  );

  tx_state_e state;
  tx_state_e next_state;
  logic tx_clock_prev;
  logic core_tick;
  logic [1:0] settle;
  logic strap_taken;
  logic [3:0] strap_q;
  logic [3:0] txd;
  logic [7:0] byte_q;
  logic byte_full;
  logic byte_last;
  logic half_duplex;
  logic strap_is_ext;
  logic defer;
  logic col_abort;
  logic accept;
  logic consume;
  logic [7:0] nib_count;

  assign core_tick = sync_bus.tx_clock && !tx_clock_prev;
  assign network_core_clock_en = core_tick;
  assign strap_is_ext = (sync_bus.strap == mii_tx_pkg::STRAP_EXT_PHY_A) ||
                        (sync_bus.strap == mii_tx_pkg::STRAP_EXT_PHY_B);
  assign half_duplex = sync_bus.duplex_n;
  assign full_duplex = !sync_bus.duplex_n;
  assign defer = half_duplex && sync_bus.carrier;
  assign col_abort = core_tick && half_duplex && sync_bus.collision && (state != st_idle);
  assign tx_ready = mii_port_enabled && !byte_full;
  assign accept = tx_ready && tx_valid;
  assign consume = core_tick && !col_abort && (state == st_high);
  assign mii_tx_nibble_msb = txd[3];
  assign mii_tx_nibble_low = txd[2:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_clock_prev <= 1'b0;
    end else begin
      tx_clock_prev <= sync_bus.tx_clock;
    end
  end

  // strap caught after the sync stages settle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle <= mii_tx_pkg::SETTLE_RESET;
      strap_taken <= 1'b0;
      mii_port_enabled <= 1'b0;
      strap_q <= mii_tx_pkg::NIBBLE_IDLE;
    end else if (!strap_taken) begin
      settle <= settle + 2'h1;
      if (settle == mii_tx_pkg::STRAP_SETTLE) begin
        strap_taken <= 1'b1;
        mii_port_enabled <= strap_is_ext;
        strap_q <= sync_bus.strap;
      end
    end
  end

  // holding byte; a fresh accept wins over the consume of the old byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_q <= 8'h00;
      byte_last <= 1'b0;
      byte_full <= 1'b0;
    end else if (accept) begin
      byte_q <= tx_data;
      byte_last <= tx_last;
      byte_full <= 1'b1;
    end else if (consume || col_abort) begin
      byte_full <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (byte_full && !defer) begin
          next_state = st_high;
        end
      end
      st_high: begin
        next_state = byte_last ? st_stop : st_low;
      end
      st_low: begin
        next_state = byte_full ? st_high : st_idle;
      end
      st_stop: begin
        next_state = st_idle;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    if (col_abort) begin
      next_state = st_idle;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !mii_port_enabled) begin
      state <= st_idle;
      txd <= mii_tx_pkg::NIBBLE_IDLE;
      mii_transmit_valid <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_abort <= col_abort;
      // nibble updates only on link clock edges
      if (core_tick) begin
        state <= next_state;
        // low nibble first, bit 3 msb
        if (next_state == st_high) begin
          txd <= byte_q[3:0];
          mii_transmit_valid <= 1'b1;
        end else if (next_state == st_low || next_state == st_stop) begin
          txd <= byte_q[7:4];
          mii_transmit_valid <= 1'b1;
        end else begin
          txd <= mii_tx_pkg::NIBBLE_IDLE;
          mii_transmit_valid <= 1'b0;
        end
      end
    end
  end

  // nibble count of the running frame, read only by checks
  always_ff @(posedge clk) begin
    if (!rst_n || !mii_transmit_valid) begin
      nib_count <= mii_tx_pkg::COUNT_RESET;
    end else if (core_tick) begin
      nib_count <= nib_count + 8'h01;
    end
  end

  a_quiet_when_off: assert property (@(posedge clk) disable iff (!rst_n)
    !mii_port_enabled |-> !mii_transmit_valid && txd == mii_tx_pkg::NIBBLE_IDLE)
    else $error("outputs active while port disabled");

  a_strap_code_ok: assert property (@(posedge clk) disable iff (!rst_n)
    mii_port_enabled |-> (strap_q == mii_tx_pkg::STRAP_EXT_PHY_A || strap_q == mii_tx_pkg::STRAP_EXT_PHY_B))
    else $error("port enabled by a non external strap");

  a_start_on_tick: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mii_transmit_valid) |-> $past(core_tick) && txd == $past(byte_q[3:0]))
    else $error("enable rose without first nibble on a link edge");

  a_whole_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(mii_transmit_valid) && !tx_abort && mii_port_enabled |-> nib_count[0] == 1'b0)
    else $error("frame ended on an odd nibble");

  a_data_held: assert property (@(posedge clk) disable iff (!rst_n)
    !core_tick && mii_port_enabled |=> $stable(txd) && $stable(mii_transmit_valid))
    else $error("nibble changed between link edges");

  a_high_nibble: assert property (@(posedge clk) disable iff (!rst_n)
    core_tick && state == st_high && !col_abort && mii_port_enabled |=> txd == $past(byte_q[7:4]))
    else $error("second nibble is not the high half");

  a_col_halfdup: assert property (@(posedge clk) disable iff (!rst_n)
    tx_abort |-> $past(half_duplex) && $past(sync_bus.collision) && !mii_transmit_valid)
    else $error("abort without half duplex collision");

  a_defer_carrier: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(mii_transmit_valid) |-> !$past(defer))
    else $error("frame started on busy medium");

  a_tick_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    network_core_clock_en |=> !network_core_clock_en)
    else $error("core enable longer than one cycle");
endmodule // mii_transmit_side_port
`default_nettype wire

// ### verification/phy_model.sv
/*
  behavioural mii phy: free running transmit clock, medium status, nibble capture.
  assumes the transmitter moves its pins well away from the link clock's rising edge.
*/
`default_nettype none
module phy_model (
  input wire logic medium_busy,
  input wire logic medium_clash,
  input wire logic tx_en,
  input wire logic [3:0] nibble,
  output var logic tx_clock,
  output logic carrier,
  output logic collision,
  output var logic [7:0] rx_byte,
  output var logic rx_strobe,
  output var logic frame_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic half;
  logic was_en;
  logic [3:0] low;
  initial begin
    tx_clock = 1'b0;
    {half, was_en, low, rx_byte, rx_strobe, frame_end} = '0;
  end
  always #80 tx_clock = ~tx_clock;
  assign carrier = medium_busy;
  assign collision = medium_clash;
  // low nibble first; strobe drops each edge so every byte gives a fresh rise
  always @(posedge tx_clock) begin
    rx_strobe <= 1'b0;
    frame_end <= was_en & ~tx_en;
    was_en <= tx_en;
    if (tx_en) begin
      half <= ~half;
      low <= nibble;
      if (half) begin
        rx_byte <= {nibble, low};
        rx_strobe <= 1'b1;
      end
    end else begin
      half <= 1'b0;
    end
  end
endmodule // phy_model
`default_nettype wire

// ### verification/tb_top.sv
/*
  self-checking bench for the mii transmit port with a behavioural phy.
  assumes clk at 50 MHz; the phy link clock runs free at 160 ns.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, busy, clash, duplex_select_n, tx_last, tx_valid, tx_ready, tx_abort, core_en, enabled;
  logic full_duplex, txen, nib_msb, link_clk, carrier, collision, rx_strobe, frame_end;
  logic [2:0] nib_low;
  logic [3:0] strap;
  logic [7:0] tx_data, rx_byte;
  logic [31:0] seed;
  logic [7:0] expq[$];
  int mismatches, num_checks, frames, aborts, n, s;
  mii_transmit_side_port DUT (.clk(clk), .rst_n(rst_n), .mii_tx_clock_in(link_clk), .mii_carrier_in(carrier),
    .mii_collision_in(collision), .duplex_select_n(duplex_select_n), .phy_select_strap(strap),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_abort(tx_abort),
    .network_core_clock_en(core_en), .mii_port_enabled(enabled), .full_duplex(full_duplex),
    .mii_transmit_valid(txen), .mii_tx_nibble_msb(nib_msb), .mii_tx_nibble_low(nib_low));
  phy_model phy (.medium_busy(busy), .medium_clash(clash), .tx_en(txen), .nibble({nib_msb, nib_low}),
    .tx_clock(link_clk), .carrier(carrier), .collision(collision), .rx_byte(rx_byte),
    .rx_strobe(rx_strobe), .frame_end(frame_end));
  initial clk = 1'b0;
  always #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] code);
    @(negedge clk);
    rst_n = 1'b0;
    strap = code;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  // bytes held until taken; valid stays up so the holding slot never underruns
  task automatic send_frame(input int len, input logic keep);
    int k, w;
    for (k = 0; k < len; k++) begin
      @(negedge clk);
      seed = xs(seed);
      tx_data = seed[7:0];
      tx_last = (k == len - 1);
      tx_valid = 1'b1;
      if (keep) expq.push_back(seed[7:0]);
      w = 0;
      // ready is settled at the falling edge, so no race with the edge that takes the byte
      while (tx_ready !== 1'b1 && w < 2000) begin
        @(negedge clk);
        w++;
      end
      if (w >= 2000) check("ready wait", 32'h0000_0001, 32'h0000_0000);
      @(posedge clk);
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  // eight clk cycles span exactly one link tick
  task automatic clash_pulse;
    repeat (60) @(negedge clk);
    clash = 1'b1;
    repeat (8) @(negedge clk);
    clash = 1'b0;
    repeat (120) @(negedge clk);
  endtask
  always @(posedge rx_strobe) if (expq.size() > 0) check("rx byte", 32'(expq.pop_front()), 32'(rx_byte));
  always @(posedge frame_end) frames++;
  // abort pulse sampled mid cycle, away from the edge that launches it
  always @(negedge clk) begin
    if (tx_abort === 1'b1) begin
      aborts++;
      check("enable at abort", 32'h0000_0000, 32'(txen));
    end
  end
  initial begin
    {rst_n, busy, clash, tx_last, tx_valid, duplex_select_n} = '0;
    strap = 4'h0;
    tx_data = 8'h00;
    seed = 32'h0001_7e07;
    for (s = 0; s < 16; s++) begin
      do_reset(4'(s));
      n = (s == 1 || s == 2);
      check("port enabled", 32'(n), 32'(enabled));
      check("ready", 32'(n), 32'(tx_ready));
      check("idle pins", 32'h0, {27'h0, txen, nib_msb, nib_low});
    end
    $display("strap test done");
    do_reset(4'h1);
    for (s = 1; s >= 0; s--) begin
      duplex_select_n = s[0];
      repeat (4) @(negedge clk);
      check("full duplex", 32'(s == 0), 32'(full_duplex));
    end
    n = 0;
    repeat (80) begin @(negedge clk); n += (core_en === 1'b1); end
    check("core ticks", 32'h0000_000a, 32'(n));
    $display("duplex and tick test done");
    fork
      send_frame(8, 1'b1);
      clash_pulse;
    join
    check("frames", 32'h0000_0001, 32'(frames));
    check("bytes left", 32'h0000_0000, 32'(expq.size()));
    check("aborts", 32'h0000_0000, 32'(aborts));
    $display("full duplex frame test done");
    duplex_select_n = 1'b1;
    busy = 1'b1;
    repeat (4) @(negedge clk);
    fork
      send_frame(4, 1'b1);
      begin
        n = 0;
        repeat (100) begin @(negedge clk); n += (txen === 1'b1); end
        check("deferred", 32'h0000_0000, 32'(n));
        busy = 1'b0;
        repeat (150) @(negedge clk);
      end
    join
    check("frames", 32'h0000_0002, 32'(frames));
    check("bytes left", 32'h0000_0000, 32'(expq.size()));
    $display("carrier defer test done");
    fork
      send_frame(8, 1'b0);
      clash_pulse;
    join
    repeat (150) @(negedge clk);
    check("aborts", 32'h0000_0001, 32'(aborts));
    $display("collision test done");
    end_sim;
  end
  // tests need about 1100 clk cycles
  initial begin
    #200_000;
    mismatches++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
